// *** core/serial_pkg.sv ***
package serial_pkg;

  // register addresses
  localparam logic [15:0] ADDR_MODE   = 16'hffa0;
  localparam logic [15:0] ADDR_STAT   = 16'hffa1;
  localparam logic [15:0] ADDR_BAUD   = 16'hffa2;
  localparam logic [15:0] ADDR_TXSH   = 16'hffa3;
  localparam logic [15:0] ADDR_RXBUF  = 16'hffa4;
  localparam logic [15:0] ADDR_TXFLAG = 16'hffa5;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] BAUD_WMASK = 8'h7f;
  localparam logic [7:0] CHAR7_MASK = 8'h7f;

  // status bit positions
  localparam int STAT_PE  = 2;
  localparam int STAT_FE  = 1;
  localparam int STAT_OVE = 0;

  localparam logic [2:0] LAST_BIT_8 = 3'h7;
  localparam logic [2:0] LAST_BIT_7 = 3'h6;
  localparam logic [2:0] PRESC_EXT  = 3'h0;
  localparam logic [4:0] DIV_BASE   = 5'h10;

  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ZERO = 2'b01,
    PAR_ODD  = 2'b10,
    PAR_EVEN = 2'b11
  } parity_t;

  typedef struct packed {
    logic    tx_en;
    logic    rx_en;
    parity_t parity;
    logic    char8;
    logic    stop2;
    logic    err_no_irq;
    logic    irda;
  } mode_t;

  typedef struct packed {
    logic       zero;
    logic [2:0] presc;
    logic [3:0] div;
  } baud_t;

endpackage

// *** core/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync
  import serial_pkg::*;
#(
  parameter int         W   = 1,
  parameter logic [0:0] RST = 1'b1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // pins and synchronised levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o,
  output logic      [W-1:0] q_prev_o
);

  logic [W-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff  <= {W{RST}};
      q_o      <= {W{RST}};
      q_prev_o <= {W{RST}};
    end else begin
      meta_ff  <= d_i;
      q_o      <= meta_ff;
      q_prev_o <= q_o;
    end
  end

endmodule

// *** core/baud_gen.sv ***
`timescale 1ns/1ps
module baud_gen
  import serial_pkg::*;
(
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  nrst_i,
  // configuration and control
  input  wire baud_t cfg_i,
  input  wire logic  ext_rise_i,
  input  wire logic  restart_i,
  // half-bit enable pulse
  output logic       half_tick_o
);

  logic [6:0] pre_ff;
  logic [4:0] cnt_ff;
  logic [6:0] mask;
  logic       src_tick;
  logic [4:0] last_cnt;

  always_comb begin
    mask     = 7'((8'h01 << cfg_i.presc) - 8'h01);
    last_cnt = DIV_BASE + {1'b0, cfg_i.div} - 5'h01;
    if (cfg_i.presc == PRESC_EXT) begin
      src_tick = ext_rise_i;
    end else begin
      src_tick = (pre_ff & mask) == mask;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_ff <= '0;
    end else if (restart_i) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 7'h01;
    end
  end

  // wraps every 16+k source ticks; two wraps make one bit time
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff      <= '0;
      half_tick_o <= 1'b0;
    end else if (restart_i) begin
      cnt_ff      <= '0;
      half_tick_o <= 1'b0;
    end else if (src_tick && cnt_ff == last_cnt) begin
      cnt_ff      <= '0;
      half_tick_o <= 1'b1;
    end else begin
      cnt_ff      <= src_tick ? cnt_ff + 5'h01 : cnt_ff;
      half_tick_o <= 1'b0;
    end
  end

  div_wrap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (src_tick && !restart_i && cnt_ff == last_cnt) |=> (half_tick_o && cnt_ff == 5'h00))
    else $error("divider did not wrap at 16+k");

  presc_rate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cfg_i.presc != PRESC_EXT && src_tick && !restart_i)
      |=> (cfg_i.presc == PRESC_EXT || !src_tick))
    else $error("prescaler ticked on consecutive cycles");

endmodule

// *** core/uart_async.sv ***
`timescale 1ns/1ps
module uart_async
  import serial_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  // cpu register port
  input  wire logic [15:0] ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  // serial pins
  input  wire logic        RXD_I,
  input  wire logic        EXT_SCLK_I,
  output logic             TXD_O,
  // event pulses
  output logic             TX_DONE_IRQ_O,
  output logic             RX_DONE_IRQ_O,
  output logic             RX_ERR_IRQ_O
);

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_CHECK, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction

  function automatic logic [7:0] char_data(input logic [7:0] d, input logic c8);
    char_data = c8 ? d : (d & CHAR7_MASK);
  endfunction

  mode_t      mode_ff;
  baud_t      baud_ff;
  logic [2:0] stat_ff;
  logic [7:0] rxb_ff;
  logic       rxb_full_ff;
  logic       txdone_ff;

  tx_state_t  tx_state_ff;
  logic [7:0] tx_sh_ff;
  logic [2:0] tx_cnt_ff;
  logic       tx_par_ff;
  logic       tx_phase_ff;
  logic       tx_stop2nd_ff;

  rx_state_t  rx_state_ff;
  logic [7:0] rx_sh_ff;
  logic [2:0] rx_cnt_ff;
  logic       rx_par_ff;
  logic       rx_phase_ff;

  logic       rx_s;
  logic       rx_prev;
  logic       sclk_s;
  logic       sclk_prev;
  logic       tx_tick;
  logic       rx_tick;

  logic       wr_txsh;
  logic       rd_rxb;
  logic       tx_go;
  logic       tx_bit_end;
  logic       tx_end;
  logic       rx_fall;
  logic       rx_confirm;
  logic       rx_restart;
  logic       rx_sample;
  logic       rx_done;
  logic       rx_pe;
  logic       rx_fe;
  logic       rx_ove;
  logic [2:0] last_bit;

  pin_sync #(.W(2), .RST(1'b1)) u_sync (
    .clk_i    (CLK_I),
    .nrst_i   (NRST_I),
    .d_i      ({RXD_I, EXT_SCLK_I}),
    .q_o      ({rx_s, sclk_s}),
    .q_prev_o ({rx_prev, sclk_prev})
  );

  baud_gen u_tx_baud (
    .clk_i       (CLK_I),
    .nrst_i      (NRST_I),
    .cfg_i       (baud_ff),
    .ext_rise_i  (sclk_s & ~sclk_prev),
    .restart_i   (tx_go),
    .half_tick_o (tx_tick)
  );

  baud_gen u_rx_baud (
    .clk_i       (CLK_I),
    .nrst_i      (NRST_I),
    .cfg_i       (baud_ff),
    .ext_rise_i  (sclk_s & ~sclk_prev),
    .restart_i   (rx_restart),
    .half_tick_o (rx_tick)
  );

  always_comb begin
    wr_txsh    = WR_I && hit(ADDR_I, ADDR_TXSH);
    rd_rxb     = RD_I && hit(ADDR_I, ADDR_RXBUF);
    last_bit   = mode_ff.char8 ? LAST_BIT_8 : LAST_BIT_7;
    tx_go      = wr_txsh && mode_ff.tx_en && tx_state_ff == TX_IDLE;
    tx_bit_end = tx_tick && tx_phase_ff;
    tx_end     = tx_bit_end && tx_state_ff == TX_STOP && (!mode_ff.stop2 || tx_stop2nd_ff);
    rx_fall    = rx_prev && !rx_s;
    rx_confirm = rx_state_ff == RX_CHECK && rx_tick && !rx_s;
    rx_restart = (rx_state_ff == RX_IDLE && mode_ff.rx_en && rx_fall) || rx_confirm;
    rx_sample  = rx_tick && rx_phase_ff;
    rx_done    = mode_ff.rx_en && rx_state_ff == RX_STOP && rx_sample;
    rx_fe      = !rx_s;
    rx_ove     = rxb_full_ff && !rd_rxb;
    unique case (mode_ff.parity)
      PAR_EVEN: rx_pe = ^char_data(rx_sh_ff, mode_ff.char8) ^ rx_par_ff;
      PAR_ODD:  rx_pe = ~(^char_data(rx_sh_ff, mode_ff.char8) ^ rx_par_ff);
      PAR_ZERO: rx_pe = 1'b0;
      PAR_NONE: rx_pe = 1'b0;
    endcase
  end

  // register writes
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mode_ff <= mode_t'(RESET_BYTE);
      baud_ff <= baud_t'(RESET_BYTE);
    end else if (WR_I) begin
      if (hit(ADDR_I, ADDR_MODE)) begin
        mode_ff <= mode_t'(WDATA_I);
      end
      if (hit(ADDR_I, ADDR_BAUD)) begin
        baud_ff <= baud_t'(WDATA_I & BAUD_WMASK);
      end
    end
  end

  // register reads, one cycle late
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      RDATA_O <= RESET_BYTE;
    end else if (RD_I) begin
      unique case (1'b1)
        hit(ADDR_I, ADDR_MODE):   RDATA_O <= mode_ff;
        hit(ADDR_I, ADDR_STAT):   RDATA_O <= {5'h00, stat_ff};
        hit(ADDR_I, ADDR_BAUD):   RDATA_O <= baud_ff;
        hit(ADDR_I, ADDR_RXBUF):  RDATA_O <= rxb_ff;
        hit(ADDR_I, ADDR_TXFLAG): RDATA_O <= {7'h00, txdone_ff};
        default:                  RDATA_O <= RESET_BYTE;
      endcase
    end
  end

  // transmitter
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_state_ff   <= TX_IDLE;
      TXD_O         <= 1'b1;
      tx_sh_ff      <= '0;
      tx_cnt_ff     <= '0;
      tx_par_ff     <= 1'b0;
      tx_phase_ff   <= 1'b0;
      tx_stop2nd_ff <= 1'b0;
    end else if (tx_go) begin
      tx_state_ff <= TX_START;
      TXD_O       <= 1'b0;
      tx_sh_ff    <= char_data(WDATA_I, mode_ff.char8);
      tx_par_ff   <= (mode_ff.parity == PAR_EVEN) ? ^char_data(WDATA_I, mode_ff.char8)
                   : (mode_ff.parity == PAR_ODD)  ? ~^char_data(WDATA_I, mode_ff.char8)
                   : 1'b0;
      tx_phase_ff <= 1'b0;
    end else if (tx_tick) begin
      tx_phase_ff <= ~tx_phase_ff;
      if (tx_phase_ff) begin
        unique case (tx_state_ff)
          TX_IDLE: TXD_O <= 1'b1;
          TX_START: begin
            tx_state_ff <= TX_DATA;
            TXD_O       <= tx_sh_ff[0];
            tx_sh_ff    <= tx_sh_ff >> 1;
            tx_cnt_ff   <= '0;
          end
          TX_DATA: begin
            if (tx_cnt_ff == last_bit) begin
              tx_state_ff   <= (mode_ff.parity == PAR_NONE) ? TX_STOP : TX_PAR;
              TXD_O         <= (mode_ff.parity == PAR_NONE) ? 1'b1 : tx_par_ff;
              tx_stop2nd_ff <= 1'b0;
            end else begin
              tx_cnt_ff <= tx_cnt_ff + 3'h1;
              TXD_O     <= tx_sh_ff[0];
              tx_sh_ff  <= tx_sh_ff >> 1;
            end
          end
          TX_PAR: begin
            tx_state_ff   <= TX_STOP;
            TXD_O         <= 1'b1;
            tx_stop2nd_ff <= 1'b0;
          end
          TX_STOP: begin
            if (mode_ff.stop2 && !tx_stop2nd_ff) begin
              tx_stop2nd_ff <= 1'b1;
            end else begin
              tx_state_ff <= TX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // completion flag: set wins over the software clear
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      txdone_ff     <= 1'b0;
      TX_DONE_IRQ_O <= 1'b0;
    end else begin
      TX_DONE_IRQ_O <= tx_end;
      if (tx_end) begin
        txdone_ff <= 1'b1;
      end else if (WR_I && hit(ADDR_I, ADDR_TXFLAG)) begin
        txdone_ff <= 1'b0;
      end
    end
  end

  // receiver; clearing the enable aborts without touching buffer or status
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rx_state_ff <= RX_IDLE;
      rx_sh_ff    <= '0;
      rx_cnt_ff   <= '0;
      rx_par_ff   <= 1'b0;
      rx_phase_ff <= 1'b0;
    end else if (!mode_ff.rx_en) begin
      rx_state_ff <= RX_IDLE;
    end else if (rx_restart) begin
      rx_state_ff <= (rx_state_ff == RX_IDLE) ? RX_CHECK : RX_DATA;
      rx_phase_ff <= 1'b0;
      rx_cnt_ff   <= '0;
      rx_sh_ff    <= '0;
    end else if (rx_state_ff == RX_CHECK && rx_tick) begin
      rx_state_ff <= RX_IDLE;
    end else if (rx_tick) begin
      rx_phase_ff <= ~rx_phase_ff;
      if (rx_phase_ff) begin
        unique case (rx_state_ff)
          RX_DATA: begin
            rx_sh_ff[rx_cnt_ff] <= rx_s;
            rx_cnt_ff           <= rx_cnt_ff + 3'h1;
            if (rx_cnt_ff == last_bit) begin
              rx_state_ff <= (mode_ff.parity == PAR_NONE) ? RX_STOP : RX_PAR;
            end
          end
          RX_PAR:  begin
            rx_par_ff   <= rx_s;
            rx_state_ff <= RX_STOP;
          end
          RX_STOP: rx_state_ff <= RX_IDLE;
          default: rx_state_ff <= RX_IDLE;
        endcase
      end
    end
  end

  // holding buffer and error status
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rxb_ff        <= RESET_BYTE;
      rxb_full_ff   <= 1'b0;
      stat_ff       <= '0;
      RX_DONE_IRQ_O <= 1'b0;
      RX_ERR_IRQ_O  <= 1'b0;
    end else if (rx_done) begin
      rxb_ff        <= char_data(rx_sh_ff, mode_ff.char8);
      rxb_full_ff   <= 1'b1;
      stat_ff       <= {rx_pe, rx_fe, rx_ove};
      RX_ERR_IRQ_O  <= rx_pe | rx_fe | rx_ove;
      RX_DONE_IRQ_O <= !(mode_ff.err_no_irq && (rx_pe | rx_fe | rx_ove));
    end else begin
      RX_DONE_IRQ_O <= 1'b0;
      RX_ERR_IRQ_O  <= 1'b0;
      if (rd_rxb) begin
        rxb_full_ff <= 1'b0;
        stat_ff     <= '0;
      end
    end
  end

  sequence fall_seen;
    rx_state_ff == RX_IDLE && mode_ff.rx_en && rx_fall;
  endsequence

  start_check_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    fall_seen |=> rx_state_ff == RX_CHECK)
    else $error("falling edge did not start the half-bit check");
  overrun_set_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (rx_done && rxb_full_ff && !rd_rxb) |=> stat_ff[STAT_OVE])
    else $error("overrun not flagged on unread buffer");
  first_stop_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (rx_done && rx_s) |=> !stat_ff[STAT_FE])
    else $error("framing error with valid first stop bit");
  baud_bit7_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !baud_ff.zero)
    else $error("baud register bit7 not zero");
  tx_start_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    tx_go |=> (!TXD_O && tx_state_ff == TX_START))
    else $error("write did not start a frame");
  line_idle_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (tx_state_ff == TX_IDLE && $past(tx_state_ff) == TX_IDLE) |-> TXD_O)
    else $error("transmit line not high while idle");
  zero_par_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (rx_done && mode_ff.parity == PAR_ZERO) |=> !stat_ff[STAT_PE])
    else $error("parity error reported in zero parity mode");
  rxb_bit7_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (rx_done && !mode_ff.char8) |=> !rxb_ff[7])
    else $error("bit7 set in 7-bit reception");
  tx_done_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    tx_end |=> (txdone_ff && TX_DONE_IRQ_O && tx_state_ff == TX_IDLE))
    else $error("transmit completion not flagged");
  err_clear_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (rd_rxb && !rx_done) |=> (stat_ff == 3'h0 && !rxb_full_ff))
    else $error("status not cleared by buffer read");

endmodule

// *** tb/serial_peer.sv ***
`timescale 1ns/1ps
module serial_peer
  import serial_pkg::*;
(
  // clock and pins
  input  wire logic clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  initial rxd_o = 1'b1; // pulled-up idle line

  function automatic logic par_of(logic [7:0] d, logic c8, parity_t p);
    logic x;
    x = ^(c8 ? d : d & CHAR7_MASK);
    return (p == PAR_EVEN) ? x : (p == PAR_ODD) ? ~x : 1'b0;
  endfunction

  // falling edge only, so the line never moves on the design's sampling edge
  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // bp flips the parity bit, sv is the stop level, both for fault frames
  task automatic send(input logic [7:0] d, input logic c8, input parity_t p,
                      input int bt, input logic bp, input logic sv);
    rxd_o = 1'b0;
    hold(bt);
    for (int i = 0; i < (c8 ? 8 : 7); i++) begin
      rxd_o = d[i]; // lsb first
      hold(bt);
    end
    if (p != PAR_NONE) begin
      rxd_o = par_of(d, c8, p) ^ bp;
      hold(bt);
    end
    rxd_o = sv;
    hold(bt);
    rxd_o = 1'b1;
    hold(bt);
  endtask

  task automatic grab(input logic c8, input parity_t p, input logic s2, input int bt,
                      output logic [7:0] d, output logic pb, output logic ok);
    int i;
    d = 8'h00;
    pb = 1'b0;
    i = 0;
    while (txd_i !== 1'b0 && i < 4000) begin
      @(negedge clk_i);
      i++;
    end
    // sample at bit centres so edge jitter of the source tick is tolerated
    hold(bt / 2);
    ok = (txd_i === 1'b0);
    for (i = 0; i < (c8 ? 8 : 7); i++) begin
      hold(bt);
      d[i] = txd_i;
    end
    if (p != PAR_NONE) begin
      hold(bt);
      pb = txd_i;
    end
    hold(bt);
    ok &= (txd_i === 1'b1);
    if (s2) begin
      hold(bt);
      ok &= (txd_i === 1'b1);
    end
  endtask
endmodule

// *** tb/async_serial_baud_tx_frame_tb_top.sv ***
`timescale 1ns/1ps
module async_serial_baud_tx_frame_tb_top;
  import serial_pkg::*;
  logic        CLK_I      = 1'b0;
  logic        NRST_I     = 1'b0;
  logic [15:0] ADDR_I     = 16'h0000;
  logic [7:0]  WDATA_I    = 8'h00;
  logic        WR_I       = 1'b0;
  logic        RD_I       = 1'b0;
  logic        EXT_SCLK_I = 1'b0;
  logic [7:0]  RDATA_O;
  logic        RXD_I;
  logic        TXD_O;
  logic        TX_DONE_IRQ_O;
  logic        RX_DONE_IRQ_O;
  logic        RX_ERR_IRQ_O;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int rx_done_n = 0;
  int rx_err_n = 0;
  int tx_done_n = 0;
  int tx_done_at = 0;
  int wr_at = 0;
  int txd_low = 0;
  // model of unread received characters; the holding buffer shows the newest
  logic [7:0] rx_q[$];

  uart_async uart_async_inst (.CLK_I(CLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .RXD_I(RXD_I),
    .EXT_SCLK_I(EXT_SCLK_I), .TXD_O(TXD_O), .TX_DONE_IRQ_O(TX_DONE_IRQ_O),
    .RX_DONE_IRQ_O(RX_DONE_IRQ_O), .RX_ERR_IRQ_O(RX_ERR_IRQ_O));
  serial_peer serial_peer_inst (.clk_i(CLK_I), .txd_i(TXD_O), .rxd_o(RXD_I));

  always #4 CLK_I = ~CLK_I;
  // free-running source clock, 6 system clocks per period
  always #24 EXT_SCLK_I = ~EXT_SCLK_I;

  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    if (RX_DONE_IRQ_O === 1'b1) rx_done_n <= rx_done_n + 1;
    if (RX_ERR_IRQ_O === 1'b1) rx_err_n <= rx_err_n + 1;
    if (TX_DONE_IRQ_O === 1'b1) tx_done_n <= tx_done_n + 1;
    if (TX_DONE_IRQ_O === 1'b1) tx_done_at <= cyc;
    if (WR_I === 1'b1 && ADDR_I === ADDR_TXSH) wr_at <= cyc;
    if (TXD_O !== 1'b1) txd_low <= txd_low + 1;
    if (cyc == 50000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks=%0d bad=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge CLK_I);
    ADDR_I = a;
    WDATA_I = d;
    WR_I = 1'b1;
    @(negedge CLK_I);
    WR_I = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(negedge CLK_I);
    ADDR_I = a;
    RD_I = 1'b1;
    @(negedge CLK_I);
    RD_I = 1'b0;
    v = RDATA_O;
  endtask

  // mode only changes between frames, never mid transfer
  task automatic txf(input logic [7:0] d, input logic c8, input parity_t p,
                     input logic s2, input int bt, input int tol);
    logic [7:0] got;
    logic pb;
    logic ok;
    int nb;
    int n;
    nb = 2 + (c8 ? 8 : 7) + int'(p != PAR_NONE) + int'(s2);
    wr(ADDR_MODE, {1'b1, 1'b0, p, c8, s2, 2'b00});
    n = tx_done_n;
    fork
      serial_peer_inst.grab(c8, p, s2, bt, got, pb, ok);
      wr(ADDR_TXSH, d);
    join
    check(got, c8 ? d : d & CHAR7_MASK);
    check(pb, serial_peer_inst.par_of(d, c8, p));
    check(ok, 1'b1);
    for (int i = 0; i < 2 * bt && tx_done_n == n; i++) @(posedge CLK_I);
    @(negedge CLK_I);
    n = tx_done_at - wr_at - nb * bt - 1;
    check(n >= -tol && n <= tol, 1'b1);
    rd(ADDR_TXFLAG, got);
    check(got[0], 1'b1);
    wr(ADDR_TXFLAG, 8'h00);
    rd(ADDR_TXFLAG, got);
    check(got[0], 1'b0);
  endtask

  task automatic rxf(input logic [7:0] d, input logic c8, input parity_t p,
                     input logic bp, input logic sv, input logic rd_it);
    logic [7:0] v;
    logic [2:0] st;
    int n;
    int e;
    st = {bp & p[1], ~sv, rx_q.size() != 0};
    n = rx_done_n;
    e = rx_err_n;
    // two stops selected, peer sends one: only the first is judged
    wr(ADDR_MODE, {1'b0, 1'b1, p, c8, 1'b1, 2'b00});
    serial_peer_inst.send(d, c8, p, 64, bp, sv);
    check(rx_done_n - n, 1);
    check(rx_err_n - e, st != 3'h0);
    rx_q.push_back(c8 ? d : d & CHAR7_MASK);
    if (rd_it) begin
      rd(ADDR_STAT, v);
      check(v, {5'h00, st});
      rd(ADDR_RXBUF, v);
      check(v, rx_q[$]);
      rd(ADDR_STAT, v);
      check(v, 8'h00);
      rx_q.delete();
    end
  endtask

  initial begin
    logic [7:0] v;
    int i;
    int n;
    v = 8'($urandom(32'hf2335b2c));
    repeat (20) @(posedge CLK_I);
    @(negedge CLK_I);
    NRST_I = 1'b1;
    for (i = 0; i < 7; i++) begin
      if (i != 3) begin
        rd(ADDR_MODE + 16'(i), v);
        check(v, RESET_BYTE);
      end
    end
    wr(ADDR_BAUD, 8'hff);
    rd(ADDR_BAUD, v);
    check(v, 8'hff & BAUD_WMASK);
    wr(ADDR_BAUD, 8'h10);
    for (i = 0; i < 8; i++) begin
      txf(8'($urandom), i[2], parity_t'(i[1:0]), 1'($urandom), 64, 2);
    end
    // transmit enable clear: write must be refused
    wr(ADDR_MODE, 8'h40);
    n = txd_low;
    wr(ADDR_TXSH, 8'h00);
    repeat (200) @(posedge CLK_I);
    check(txd_low - n, 0);
    wr(ADDR_BAUD, 8'h32); // n=3 k=2: 2^4*18 clocks per bit
    txf(8'($urandom), 1'b1, PAR_EVEN, 1'b1, 288, 3);
    wr(ADDR_BAUD, 8'h00); // pin source: 32 edges of 6 clocks
    txf(8'($urandom), 1'b1, PAR_ODD, 1'b0, 192, 12);
    wr(ADDR_BAUD, 8'h10);
    wr(ADDR_MODE, 8'h80);
    n = rx_done_n;
    serial_peer_inst.send(8'h5a, 1'b1, PAR_NONE, 64, 1'b0, 1'b1);
    check(rx_done_n - n, 0);
    for (i = 0; i < 8; i++) begin
      rxf(8'($urandom), 1'($urandom), parity_t'(i[1:0]), i[2], 1'b1, 1'b1);
    end
    rxf(8'($urandom), 1'b1, PAR_NONE, 1'b0, 1'b0, 1'b1);
    rxf(8'($urandom), 1'b1, PAR_ODD, 1'b0, 1'b1, 1'b0);
    rxf(8'($urandom), 1'b0, PAR_EVEN, 1'b0, 1'b1, 1'b0);
    rxf(8'($urandom), 1'b1, PAR_ZERO, 1'b0, 1'b1, 1'b1);
    // completion pulse withheld on error, error pulse and status still given
    v = 8'($urandom);
    rx_q.push_back(v);
    wr(ADDR_MODE, 8'h4a);
    n = rx_done_n;
    i = rx_err_n;
    serial_peer_inst.send(v, 1'b1, PAR_NONE, 64, 1'b0, 1'b0);
    check(rx_done_n - n, 0);
    check(rx_err_n - i, 1);
    rd(ADDR_STAT, v);
    check(v, 8'h02);
    rd(ADDR_RXBUF, v);
    check(v, rx_q[$]);
    rx_q.delete();
    conclude();
  end
endmodule
